// File: hdl/csr_pkg.sv
// Package for the clock source and reset control block
//
// Behaviour
// - Writing one to the supervisor-disable bit turns the low-voltage supervisor off.
// - Precision tuning bit 2 acts only on the internal oscillator; trims after traffic.
// - Internal mode: bit 1 set holds resonator output high, clear drives clock out.
// - Setting bit 0 halts CPU, stops internal oscillator, starts the external one.
// - Clearing bit 0 does nothing now; its value picks the clock at suspend wake.
// - Internal mode: resonator input has weak pull-down, readable as port 2 bit 1.
// - When the external clock is stable, clock distribution restarts from it.
// - After the switch, release CPU after 128 us (bit clear) or 4 ms (bit set).
// - External mode returns to internal only on suspend wake or low-voltage reset, never on clear.
// - Power-up runs the internal oscillator and drives it onto the output pin.
// - Each reset records its cause: bit 4 low-voltage/brownout, bit 6 watchdog.
// - After any reset execution starts at 0x0000 with no stack push.
// - Reset clears every I/O register except processor status and control.
// - Reset tristates pins, disables interrupts, leaves bus operation off.
// - Low-voltage or brownout reset forces internal clock and waits supply settle.
// - Watchdog reset keeps clock mode, no settle delay, but clears bit 0.
// - Reset loads call stack and push stack pointers with zero.
// - Watchdog rollover causes reset; any write to address 0x26 clears the timer.
package csr_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam logic [7:0]  ADDR_CLK_CFG   = 8'hf8;  // Chosen address of clock config
  localparam logic [7:0]  ADDR_WDOG_CLR  = 8'h26;
  localparam logic [7:0]  ADDR_STATUS    = 8'hff;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [13:0] RESET_VECTOR   = 14'h0000;
  localparam logic [7:0]  STACK_RESET    = 8'h00;
  localparam int          BIT_EXT_EN     = 0;
  localparam int          BIT_CLKOUT_DIS = 1;
  localparam int          BIT_PRECISION  = 2;
  localparam int          BIT_SUPV_DIS   = 3;
  localparam int          BIT_RESUME     = 7;
  localparam int          BIT_LV_CAUSE   = 4;
  localparam int          BIT_WD_CAUSE   = 6;
  localparam int          RESUME_SHORT_US = 128;
  localparam int          RESUME_LONG_MS  = 4;
  localparam int          RESUME_SHORT_CYC = RESUME_SHORT_US * CLK_MHZ;
  localparam int          RESUME_LONG_CYC  = RESUME_LONG_MS * 1000 * CLK_MHZ;
  localparam int          START_US_DEF     = 1000;
  localparam int          WATCH_US_DEF     = 8000;
  localparam int          DIV_HALF         = 8;   // Clock output toggles every 8 cycles

  typedef enum logic [1:0] {
    CSR_CAUSE_NONE,
    CSR_CAUSE_LOWV,
    CSR_CAUSE_WDOG
  } csr_cause_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } csr_io_t;

  typedef struct packed {
    logic       lowv_rst;
    logic       wdog_rst;
    logic       suspend_wake;
    logic       ext_stable;
  } csr_evt_t;
endpackage

// File: hdl/csr_delay.sv
// Loadable down-counter that pulses when a delay expires
`timescale 1ns/100ps
module csr_delay (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [31:0] count,
  output logic             done
);
  import csr_pkg::*;
  logic [31:0] cnt_r;
  logic        run_r;

  // Count down, pulse done on reaching one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0;
      run_r <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_r <= count;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r <= 32'h1) begin
          run_r <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 32'h1;
        end
      end
    end
  end
endmodule

// File: hdl/csr_wdog.sv
// Watchdog timer that rolls over unless cleared
`timescale 1ns/100ps
module csr_wdog #(
  parameter int WATCH_CYC = 800000
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clear,
  output logic      roll
);
  import csr_pkg::*;
  logic [31:0] cnt_r;

  // Free count, cleared by firmware write, pulse on rollover
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0;
      roll  <= 1'b0;
    end else begin
      roll <= 1'b0;
      if (clear) begin
        cnt_r <= 32'h0;
      end else if (cnt_r >= WATCH_CYC[31:0] - 32'h1) begin
        cnt_r <= 32'h0;
        roll  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end
endmodule

// File: hdl/csr_top.sv
// Clock source selection and reset sequencing block
`timescale 1ns/100ps
module csr_top #(
  parameter int START_CYC = csr_pkg::START_US_DEF * csr_pkg::CLK_MHZ,
  parameter int WATCH_CYC = csr_pkg::WATCH_US_DEF * csr_pkg::CLK_MHZ,
  parameter int SHORT_CYC = csr_pkg::RESUME_SHORT_CYC,
  parameter int LONG_CYC  = csr_pkg::RESUME_LONG_CYC
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire csr_pkg::csr_io_t io_bus,
  input  wire csr_pkg::csr_evt_t evt,
  input  wire logic             resonator_input_pin,
  output logic [7:0]            rd_data,
  output logic [7:0]            status_r,
  output logic                  cpu_run,
  output logic                  int_osc_en,
  output logic                  ext_osc_en,
  output logic                  clk_dist_en,
  output logic                  resonator_output_pin,
  output logic                  resonator_output_oe,
  output logic                  input_pulldown_en,
  output logic                  port2_bit1_input,
  output logic                  precision_tune_en,
  output logic                  supervisor_en,
  output logic                  pins_hiz,
  output logic                  irq_enable_clr,
  output logic                  bus_op_off,
  output logic                  core_reset,
  output logic [13:0]           pc_start,
  output logic [7:0]            call_stack_pointer,
  output logic [7:0]            push_stack_pointer
);
  import csr_pkg::*;

  typedef enum logic [2:0] {
    ST_SETTLE,
    ST_RUN_INT,
    ST_HALT,
    ST_WAIT_STABLE,
    ST_RESUME,
    ST_RUN_EXT
  } csr_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Local signals
  csr_state_t  state_r;
  logic [7:0]  cfg_r;
  logic        ext_mode_r;
  logic        wd_roll;
  logic        lowv_req;
  logic        wd_req;
  logic        dly_load;
  logic [31:0] dly_count;
  logic        dly_done;
  logic [2:0]  div_r;
  logic        int_clk_r;
  logic        sync_rst_r;

  function automatic logic cfg_write(input csr_io_t b);
    cfg_write = b.wr && (b.addr == ADDR_CLK_CFG);
  endfunction

  assign lowv_req = evt.lowv_rst;
  assign wd_req   = (wd_roll || evt.wdog_rst) && !lowv_req;

  csr_wdog #(
    .WATCH_CYC (WATCH_CYC)
  ) u_wdog (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clear   ((io_bus.wr && io_bus.addr == ADDR_WDOG_CLR) || lowv_req),
    .roll    (wd_roll)
  );

  csr_delay u_delay (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (dly_load),
    .count   (dly_count),
    .done    (dly_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock configuration register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_r <= CFG_RESET;
    end else if (lowv_req || wd_req) begin
      cfg_r <= CFG_RESET;
    end else if (cfg_write(io_bus)) begin
      cfg_r <= io_bus.data;
    end
  end

  // Reset cause recording, cleared to the new cause bit on each low-voltage or watchdog reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_r <= STATUS_RESET;
    end else if (lowv_req) begin
      status_r <= 8'h0;
      status_r[BIT_LV_CAUSE] <= 1'b1;
    end else if (wd_req) begin
      status_r <= 8'h0;
      status_r[BIT_WD_CAUSE] <= 1'b1;
    end else if (io_bus.wr && io_bus.addr == ADDR_STATUS) begin
      status_r <= io_bus.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay selection for the sequencer
  always_comb begin
    dly_load  = 1'b0;
    dly_count = 32'h0;
    if (lowv_req) begin
      dly_load  = 1'b1;
      dly_count = START_CYC[31:0];
    end else if (state_r == ST_WAIT_STABLE && evt.ext_stable) begin
      dly_load  = 1'b1;
      dly_count = cfg_r[BIT_RESUME] ? LONG_CYC[31:0] : SHORT_CYC[31:0];
    end
  end

  // Clock-switch and reset sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r    <= ST_SETTLE;
      ext_mode_r <= 1'b0;
    end else if (lowv_req) begin
      state_r    <= ST_SETTLE;
      ext_mode_r <= 1'b0;
    end else if (wd_req) begin
      state_r <= state_r;
    end else begin
      case (state_r)
        ST_SETTLE: begin
          if (dly_done || START_CYC == 0) begin
            state_r <= ST_RUN_INT;
          end
        end
        ST_RUN_INT: begin
          if (cfg_write(io_bus) && io_bus.data[BIT_EXT_EN]) begin
            state_r    <= ST_HALT;
            ext_mode_r <= 1'b1;
          end
        end
        ST_HALT: begin
          state_r <= ST_WAIT_STABLE;
        end
        ST_WAIT_STABLE: begin
          if (evt.ext_stable) begin
            state_r <= ST_RESUME;
          end
        end
        ST_RESUME: begin
          if (dly_done) begin
            state_r <= ST_RUN_EXT;
          end
        end
        ST_RUN_EXT: begin
          if (evt.suspend_wake && !cfg_r[BIT_EXT_EN]) begin
            state_r    <= ST_RUN_INT;
            ext_mode_r <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_SETTLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal clock divider for the output pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_r     <= 3'h0;
      int_clk_r <= 1'b0;
    end else begin
      div_r <= div_r + 3'h1;
      if (div_r == 3'(DIV_HALF - 1)) begin
        int_clk_r <= ~int_clk_r;
      end
    end
  end

  // Reset strobe to the core while any reset is handled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_rst_r <= 1'b1;
    end else begin
      sync_rst_r <= lowv_req || wd_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_run              <= 1'b0;
      int_osc_en           <= 1'b1;
      ext_osc_en           <= 1'b0;
      clk_dist_en          <= 1'b1;
      resonator_output_pin <= 1'b0;
      resonator_output_oe  <= 1'b1;
      input_pulldown_en    <= 1'b1;
      port2_bit1_input     <= 1'b0;
      precision_tune_en    <= 1'b0;
      supervisor_en        <= 1'b1;
      rd_data              <= 8'h0;
    end else begin
      cpu_run     <= (state_r == ST_RUN_INT || state_r == ST_RUN_EXT) && !sync_rst_r;
      int_osc_en  <= !ext_mode_r;
      ext_osc_en  <= ext_mode_r;
      clk_dist_en <= state_r != ST_HALT && state_r != ST_WAIT_STABLE;
      // Output pin: internal clock, held high, or left to the resonator
      resonator_output_oe  <= !ext_mode_r;
      resonator_output_pin <= cfg_r[BIT_CLKOUT_DIS] ? 1'b1 : int_clk_r;
      input_pulldown_en    <= !ext_mode_r;
      port2_bit1_input     <= ext_mode_r ? 1'b0 : resonator_input_pin;
      precision_tune_en    <= cfg_r[BIT_PRECISION] && !ext_mode_r;
      supervisor_en        <= !cfg_r[BIT_SUPV_DIS];
      rd_data <= (io_bus.addr == ADDR_CLK_CFG) ? cfg_r :
                 (io_bus.addr == ADDR_STATUS) ? status_r : 8'h0;
    end
  end

  // Reset side effects on pins, stacks and program counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pins_hiz           <= 1'b1;
      irq_enable_clr     <= 1'b1;
      bus_op_off         <= 1'b1;
      core_reset         <= 1'b1;
      pc_start           <= RESET_VECTOR;
      call_stack_pointer <= STACK_RESET;
      push_stack_pointer <= STACK_RESET;
    end else begin
      pins_hiz           <= sync_rst_r;
      irq_enable_clr     <= sync_rst_r;
      bus_op_off         <= sync_rst_r;
      core_reset         <= sync_rst_r || !cpu_run;
      pc_start           <= RESET_VECTOR;
      call_stack_pointer <= STACK_RESET;
      push_stack_pointer <= STACK_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_lowv_forces_int: assert property (@(posedge clk_sys) disable iff (rst)
    lowv_req |=> state_r == ST_SETTLE && !ext_mode_r)
    else $error("low-voltage reset kept external mode");
  a_wdog_keeps_mode: assert property (@(posedge clk_sys) disable iff (rst)
    wd_req |=> ext_mode_r == $past(ext_mode_r) && state_r == $past(state_r))
    else $error("watchdog reset changed clock mode");
  a_wdog_cause_bit: assert property (@(posedge clk_sys) disable iff (rst)
    wd_req |=> status_r[BIT_WD_CAUSE])
    else $error("watchdog cause bit lost");
  a_lowv_cause_bit: assert property (@(posedge clk_sys) disable iff (rst)
    lowv_req |=> status_r[BIT_LV_CAUSE])
    else $error("low-voltage cause bit lost");
  a_ext_halts_cpu: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_HALT |=> ##1 !cpu_run)
    else $error("cpu ran during clock switch");
  a_clear_no_effect: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_RUN_EXT && !evt.suspend_wake && !lowv_req |=> ext_mode_r)
    else $error("external mode left without wake");
  a_clkout_high: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_r[BIT_CLKOUT_DIS] && !lowv_req && !wd_req |=> resonator_output_pin)
    else $error("clock output not held high");
  a_supv_disable: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_r[BIT_SUPV_DIS] |=> !supervisor_en)
    else $error("supervisor still enabled");
  a_stable_resume: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_WAIT_STABLE && evt.ext_stable && !lowv_req && !wd_req
    |=> state_r == ST_RESUME) else $error("no resume after stable clock");
  a_settle_holds_cpu: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_SETTLE |=> !cpu_run)
    else $error("cpu ran during supply settle");
  a_halt_stops_int: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_HALT |=> !clk_dist_en && !int_osc_en)
    else $error("internal clock still running in halt");
  a_wait_ext_on: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_WAIT_STABLE |=> ext_osc_en && !cpu_run)
    else $error("external oscillator off while waiting");
  a_resume_release: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_RESUME && dly_done && !lowv_req && !wd_req |=> state_r == ST_RUN_EXT)
    else $error("cpu not released after resume delay");
  a_pin_copy: assert property (@(posedge clk_sys) disable iff (rst)
    !ext_mode_r |=> port2_bit1_input == $past(resonator_input_pin) && input_pulldown_en)
    else $error("resonator input not readable");
  a_prec_int_only: assert property (@(posedge clk_sys) disable iff (rst)
    ext_mode_r |=> !precision_tune_en)
    else $error("precision tuning active in external mode");
  a_out_released: assert property (@(posedge clk_sys) disable iff (rst)
    ext_mode_r |=> !resonator_output_oe)
    else $error("output pin driven in external mode");
  a_reset_tristate: assert property (@(posedge clk_sys) disable iff (rst)
    sync_rst_r |=> pins_hiz && irq_enable_clr && bus_op_off && core_reset)
    else $error("reset side effects missing");
  a_vector_zero: assert property (@(posedge clk_sys) disable iff (rst)
    core_reset |-> pc_start == RESET_VECTOR && call_stack_pointer == STACK_RESET &&
    push_stack_pointer == STACK_RESET) else $error("start address or stacks not zero");
  a_wdog_clears_en: assert property (@(posedge clk_sys) disable iff (rst)
    wd_req |=> !cfg_r[BIT_EXT_EN])
    else $error("watchdog left external enable set");
  a_wake_to_int: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_RUN_EXT && evt.suspend_wake && !cfg_r[BIT_EXT_EN] && !lowv_req &&
    !wd_req |=> !ext_mode_r && state_r == ST_RUN_INT) else $error("wake kept external");
  a_dist_from_ext: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_RUN_EXT |=> clk_dist_en)
    else $error("clock distribution off in external mode");
endmodule

// File: bench/csr_osc_model.sv
// External resonator model that settles after a start-up time
`timescale 1ns/100ps
module csr_osc_model #(
  parameter int START = 25
) (
  input  wire logic clk_sys,
  input  wire logic ext_osc_en,
  output logic      ext_stable
);
  int cnt = 0;
  ////////////////////////////////////////////////////////////
  // Start-up count runs only while enabled; clears to zero when disabled
  always @(posedge clk_sys) begin
    cnt <= ext_osc_en ? cnt + 1 : 0;
  end
  assign ext_stable = ext_osc_en && (cnt >= START);
endmodule

// File: bench/csr_top_tb.sv
// Self-checking bench for the clock source and reset block
`timescale 1ns/100ps
module csr_top_tb;
  import csr_pkg::*;
  localparam int SH = 10;
  localparam int LG = 30;
  typedef struct {string nm; int sel; logic [7:0] msk; logic [7:0] ev;} csr_note_t;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        pin = 1'b0;
  logic        lowv = 1'b0;
  logic        wake = 1'b0;
  logic        stable, lat_ok = 1'b0;
  csr_io_t     io_bus = '0;
  csr_evt_t    evt;
  logic [7:0]  rd_data, status_r, stk_c, stk_p;
  logic [13:0] pc_start;
  logic        cpu_run, int_osc_en, ext_osc_en, clk_dist_en, res_out, res_oe;
  logic        pull_en, p2b1, prec_en, sup_en, hiz, irq_clr, bus_off, core_rst;
  logic [31:0] seed = 32'h947c;
  csr_note_t   q[$];
  csr_note_t   e;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  ////////////////////////////////////////////////////////////
  // Clock, event bundle, design and resonator
  always #5 clk_sys = ~clk_sys;
  assign evt = '{lowv, 1'b0, wake, stable};
  csr_top #(.START_CYC(20), .WATCH_CYC(200), .SHORT_CYC(SH), .LONG_CYC(LG)) dut (
    .clk_sys(clk_sys), .rst(rst), .io_bus(io_bus), .evt(evt),
    .resonator_input_pin(pin), .rd_data(rd_data), .status_r(status_r),
    .cpu_run(cpu_run), .int_osc_en(int_osc_en), .ext_osc_en(ext_osc_en),
    .clk_dist_en(clk_dist_en), .resonator_output_pin(res_out),
    .resonator_output_oe(res_oe), .input_pulldown_en(pull_en),
    .port2_bit1_input(p2b1), .precision_tune_en(prec_en),
    .supervisor_en(sup_en), .pins_hiz(hiz), .irq_enable_clr(irq_clr),
    .bus_op_off(bus_off), .core_reset(core_rst), .pc_start(pc_start),
    .call_stack_pointer(stk_c), .push_stack_pointer(stk_p));
  csr_osc_model #(.START(25)) osc (
    .clk_sys(clk_sys), .ext_osc_en(ext_osc_en), .ext_stable(stable));
  ////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] obs(int sel);
    case (sel)
      0: return rd_data;
      1: return status_r;
      2: return {cpu_run, int_osc_en, ext_osc_en, clk_dist_en, prec_en, sup_en, pull_en, p2b1};
      3: return {hiz, irq_clr, bus_off, core_rst, res_out, res_oe, 2'b00};
      4: return stk_c | stk_p | pc_start[7:0] | {2'b00, pc_start[13:8]};
      default: return {7'h00, lat_ok};
    endcase
  endfunction
  task automatic check(string nm, logic [7:0] ev, logic [7:0] sv);
    samples_checked++;
    if (sv !== ev) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ev, sv);
    end
  endtask
  task automatic note(string nm, int sel, logic [7:0] msk, logic [7:0] ev);
    @(posedge clk_sys);
    q.push_back('{nm, sel, msk, ev});
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    io_bus <= '{1'b1, a, d};
    @(posedge clk_sys);
    io_bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] ev);
    @(posedge clk_sys);
    io_bus <= '{1'b0, a, 8'h00};
    @(posedge clk_sys);
    note("rd_data", 0, 8'hff, ev);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic pulse_lowv();
    @(posedge clk_sys);
    lowv <= 1'b1;
    @(posedge clk_sys);
    lowv <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Result watcher takes the oldest note
  always @(negedge clk_sys) begin
    if (q.size() > 0) begin
      e = q.pop_front();
      check(e.nm, e.ev, obs(e.sel) & e.msk);
    end
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int n;
    logic [7:0] d;
    repeat (4) @(posedge clk_sys);
    note("reset outputs", 3, 8'hf0, 8'hf0);
    @(posedge clk_sys);
    rst <= 1'b0;
    pulse_lowv();
    wait_for(cpu_run, 1'b1, 100, n);
    note("status lowv", 1, 8'hff, 8'h10);
    note("power-up clock", 2, 8'he0, 8'hc0);
    note("pc and stacks", 4, 8'hff, 8'h00);
    rd(ADDR_CLK_CFG, 8'h00);
    d[0] = res_out;
    repeat (DIV_HALF) @(posedge clk_sys);
    lat_ok = (res_out !== d[0]) && res_oe;
    note("clock out runs", 5, 8'h01, 8'h01);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      d = {seed[7], 3'b000, seed[3:1], 1'b0};
      pin <= seed[4];
      wr(ADDR_CLK_CFG, d);
      rd(ADDR_CLK_CFG, d);
      note("cfg flags", 2, 8'h0f, {4'h0, d[2], !d[3], 1'b1, seed[4]});
      if (d[1]) note("clock out held", 3, 8'h0c, 8'h0c);
    end
    $display("config test done");
    wr(ADDR_WDOG_CLR, 8'h00);
    wr(ADDR_CLK_CFG, 8'h01);
    repeat (2) @(posedge clk_sys);
    note("halted", 2, 8'hf0, 8'h20);
    wait_for(stable, 1'b1, 100, n);
    wait_for(cpu_run, 1'b1, 100, n);
    lat_ok = n >= SH && n <= SH + 4;
    note("short resume", 5, 8'h01, 8'h01);
    note("ext run", 2, 8'hf0, 8'hb0);
    wr(ADDR_CLK_CFG, 8'h00);
    repeat (3) @(posedge clk_sys);
    note("stays ext", 2, 8'h60, 8'h20);
    $display("switch test done");
    wr(ADDR_WDOG_CLR, 8'h00);
    wait_for(cpu_run, 1'b0, 400, n);
    lat_ok = n >= 180 && n <= 220;
    note("rollover time", 5, 8'h01, 8'h01);
    note("status wdog", 1, 8'hff, 8'h40);
    rd(ADDR_CLK_CFG, 8'h00);
    note("wdog keeps ext", 2, 8'h60, 8'h20);
    wait_for(cpu_run, 1'b1, 100, n);
    @(posedge clk_sys);
    wake <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
    repeat (4) @(posedge clk_sys);
    note("wake internal", 2, 8'h60, 8'h40);
    $display("watchdog test done");
    wr(ADDR_WDOG_CLR, 8'h00);
    wr(ADDR_CLK_CFG, 8'h81);
    wait_for(stable, 1'b1, 100, n);
    wait_for(cpu_run, 1'b1, 100, n);
    lat_ok = n >= LG && n <= LG + 4;
    note("long resume", 5, 8'h01, 8'h01);
    pulse_lowv();
    wait_for(cpu_run, 1'b0, 10, n);
    wait_for(cpu_run, 1'b1, 100, n);
    lat_ok = n >= 20 && n <= 24;
    note("settle delay", 5, 8'h01, 8'h01);
    note("status lowv", 1, 8'hff, 8'h10);
    note("lowv internal", 2, 8'h60, 8'h40);
    $display("lowv test done");
    repeat (3) @(posedge clk_sys);
    finish_test();
  end
endmodule
